// ===== design/wsgp_pkg.sv
// Purpose: Shared constants for the wakeup/segment GPIO port pair
// Assumes: Word-indexed registers, byte address is four times the index
// Notes:   Port 5 and port 6 indices sit at their printed values
package wsgp_pkg;
	////////////////////////////////////////////////////////////////////
	// Widths
	localparam int           PORT_W        = 8;   // Pins per port
	localparam int           ADDR_W        = 18;  // Byte address width
	localparam int           IDX_W         = 16;  // Register index width
	////////////////////////////////////////////////////////////////////
	// Register indices (byte address = index * 4)
	localparam logic [15:0]  IDX_P5_DATA   = 16'hFFD8; // port5_data_latch
	localparam logic [15:0]  IDX_P5_DIR    = 16'hFFE8; // port5_direction
	localparam logic [15:0]  IDX_P5_PULL   = 16'hFFE2; // port5_pullup_enable
	localparam logic [15:0]  IDX_P5_WAKE   = 16'hFFCC; // port5_wakeup_select
	localparam logic [15:0]  IDX_P6_DATA   = 16'hFFD9; // port6_data_latch
	localparam logic [15:0]  IDX_P6_DIR    = 16'hFFE9; // port6_direction
	localparam logic [15:0]  IDX_P6_PULL   = 16'hFFE3; // port6_pullup_enable
	localparam logic [15:0]  IDX_DISP_CTRL = 16'hFFF0; // display_port_control
	localparam logic [15:0]  IDX_POWER     = 16'hFFF1; // Operating mode
	////////////////////////////////////////////////////////////////////
	// Reset and read-back values
	localparam logic [7:0]   RST_BYTE      = 8'h00; // All 8-bit registers
	localparam logic [3:0]   RST_SEG_FIELD = 4'h0;  // Segment field
	localparam logic [7:0]   DIR_READBACK  = 8'hFF; // Write-only readback
	localparam logic [7:0]   UNMAPPED_RD   = 8'h00; // Unmapped read value
	////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int           SEG_FIELD_LSB = 0; // segment_select_field
	localparam int           SEG_FIELD_MSB = 3;
	localparam int           POWER_LSB     = 0; // Operating mode field
	localparam int           POWER_MSB     = 2;
	////////////////////////////////////////////////////////////////////
	// Operating modes
	localparam logic [2:0]   PWR_ACTIVE    = 3'h0;
	localparam logic [2:0]   PWR_SLEEP     = 3'h1;
	localparam logic [2:0]   PWR_SUBSLEEP  = 3'h2;
	localparam logic [2:0]   PWR_STANDBY   = 3'h3;
	localparam logic [2:0]   PWR_WATCH     = 3'h4;
	localparam logic [2:0]   PWR_SUBACTIVE = 3'h5;
	localparam logic [2:0]   RST_POWER     = 3'h0;
endpackage : wsgp_pkg

// ===== design/wsgp_sync.sv
// Purpose: Two-stage synchroniser for a bus of pin levels
// Assumes: Each bit is independent; no word coherence needed
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module wsgp_sync #(
	parameter int W = 8 // Bits to synchronise
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta; // First stage, read by second only

	// Two flops, constants under reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule : wsgp_sync

// ===== design/wsgp_pin_ctl.sv
// Purpose: Per-port pin drive, enable and pull-up control
// Assumes: Settings come from the same clock domain
// Notes:   All outputs are flops; hold freezes, hiz releases drive
`timescale 1ns/1ps
module wsgp_pin_ctl #(
	parameter int W = 8 // Pins in the port
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] dir,       // 1 = output
	input  wire logic [W-1:0] data,      // Data latch
	input  wire logic [W-1:0] pullen,    // Pull-up enables
	input  wire logic [W-1:0] wake_sel,  // 1 = wakeup input
	input  wire logic [W-1:0] seg_claim, // 1 = segment output
	input  wire logic [W-1:0] seg_data,  // Segment drive level
	input  wire logic         hold,      // Sleep/subsleep freeze
	input  wire logic         hiz,       // Standby/watch release
	output logic      [W-1:0] pin_out,
	output logic      [W-1:0] pin_oe,
	output logic      [W-1:0] pull_on
);
	logic [W-1:0] gpio_out;   // General output role
	logic [W-1:0] drive;      // Pin wanted driven
	logic [W-1:0] value;      // Level wanted
	logic [W-1:0] pull_want;  // Pull-up wanted
	logic [W-1:0] next_oe;
	logic [W-1:0] next_out;
	logic [W-1:0] next_pull;

	// Segment first, then wakeup, then direction
	assign gpio_out  = ~seg_claim & ~wake_sel & dir;       // R6 R7 R11 R18 R20
	assign drive     = seg_claim | gpio_out;               // R12 R22
	assign value     = (seg_claim & seg_data) | (~seg_claim & data);
	assign pull_want = pullen & ~dir;                      // R1 R21
	// Hold keeps last state; hiz drops drive but keeps pull-up
	assign next_oe   = hold ? pin_oe  : (hiz ? '0 : drive); // R8
	assign next_out  = hold ? pin_out : (hiz ? '0 : value); // R8
	assign next_pull = hold ? pull_on : pull_want;          // R8

	// Output flops, all off after reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_oe  <= '0;
			pin_out <= '0;
			pull_on <= '0; // R3
		end else begin
			pin_oe  <= next_oe;
			pin_out <= next_out;
			pull_on <= next_pull;
		end
	end
endmodule : wsgp_pin_ctl

// ===== design/wsgp_top.sv
// Purpose: Two 8-bit GPIO ports with wakeup and segment takeover
// Assumes: Avalon-MM slave with waitrequest, one clock, async reset
// Notes:   Registers are one byte each in lane 0 of a 32-bit word
//
// Notes on behaviour
// (R1) Port 5 pull-up only while pin is input
// (R2) Port 5 pull-up register clears to zero
// (R3) Pull-ups off after any reset
// (R4) Port 5 wakeup register clears to zero
// (R5) Wakeup bit picks GPIO or wakeup input
// (R6) Upper port 5 nibble: segment on 1***
// (R7) Lower port 5 nibble: segment on 1**1
// (R8) Hold in sleep, release in standby/watch
// (R9) Port 6 read: latch if output, else pin
// (R10) Port 6 data latch clears to zero
// (R11) Port 6 direction 1 drives latch, 0 input
// (R12) Segment-claimed port 6 pins ignore settings; here the pull-up enable still acts on them
// (R13) Port 6 direction reads back all ones
// (R14) Port 6 direction clears to zero
// (R15) Port 6 registers decoded at fixed addresses
// (R16) Port 6 pull-up register read/write, clears
// (R17) Port 5 read: latch if output, else pin
// (R18) Port 5 direction 1 output, 0 input
// (R19) Port 5 direction write-only, reads ones
// (R20) Port 5 settings only for GPIO pins; here the pull-up enable also acts on wakeup and segment pins
// (R21) Port 6 pull-up only while pin is input
// (R22) Wakeup pin forwards level, never drives
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module wsgp_top
	import wsgp_pkg::*;
#(
	parameter int W = PORT_W // Pins per port
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	input  wire logic [W-1:0]      port5_pin_in,
	output logic      [W-1:0]      port5_pin_out,
	output logic      [W-1:0]      port5_pin_oe,
	output logic      [W-1:0]      port5_pullup_on,
	input  wire logic [W-1:0]      port5_segment_output,
	output logic      [W-1:0]      wakeup_input,
	input  wire logic [W-1:0]      port6_pin_in,
	output logic      [W-1:0]      port6_pin_out,
	output logic      [W-1:0]      port6_pin_oe,
	output logic      [W-1:0]      port6_pullup_on,
	input  wire logic [W-1:0]      port6_segment_output
);

	////////////////////////////////////////////////////////////////////
	// Software-visible registers

	logic [W-1:0] port5_data_latch;      // Port 5 output data
	logic [W-1:0] port5_direction;       // Port 5 direction, write-only
	logic [W-1:0] port5_pullup_enable;   // Port 5 pull-up enables
	logic [W-1:0] port5_wakeup_select;   // Port 5 wakeup role bits
	logic [W-1:0] port6_data_latch;      // Port 6 output data
	logic [W-1:0] port6_direction;       // Port 6 direction, write-only
	logic [W-1:0] port6_pullup_enable;   // Port 6 pull-up enables
	logic [3:0]   segment_select_field;  // Segment takeover code
	logic [2:0]   power_mode;            // Current operating mode

	////////////////////////////////////////////////////////////////////
	// Synchronised pin levels

	logic [W-1:0] port5_pin_sync;        // Port 5 pins after two flops
	logic [W-1:0] port6_pin_sync;        // Port 6 pins after two flops

	// Pins come from outside the clock domain
	wsgp_sync #(
		.W        (W)
	) u_sync5 (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (port5_pin_in),
		.sync_out (port5_pin_sync)
	);

	// Same for port 6
	wsgp_sync #(
		.W        (W)
	) u_sync6 (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (port6_pin_in),
		.sync_out (port6_pin_sync)
	);

	////////////////////////////////////////////////////////////////////
	// Bus decode

	logic [IDX_W-1:0] reg_index;         // Word index of the access
	logic             bus_take;          // Request completes this edge
	logic             wr_take;           // Write completes this edge
	logic             rd_sample;         // Read data captured this edge
	logic             lane0;             // Low byte lane enabled
	logic             hit_p5_data;
	logic             hit_p5_dir;
	logic             hit_p5_pull;
	logic             hit_p5_wake;
	logic             hit_p6_data;
	logic             hit_p6_dir;
	logic             hit_p6_pull;
	logic             hit_disp;
	logic             hit_power;

	// Low two address bits select a byte, not a register
	assign reg_index   = address[ADDR_W-1:2];
	assign lane0       = byteenable[0];
	// Request is answered on the edge after it is first seen
	assign bus_take    = (read | write) & ~waitrequest;
	assign wr_take     = bus_take & write & lane0;
	// Read data is formed while waitrequest is still high
	assign rd_sample   = read & waitrequest;

	// Address decode, fixed locations
	assign hit_p5_data = (reg_index == IDX_P5_DATA);
	assign hit_p5_dir  = (reg_index == IDX_P5_DIR);
	assign hit_p5_pull = (reg_index == IDX_P5_PULL);
	assign hit_p5_wake = (reg_index == IDX_P5_WAKE);
	assign hit_p6_data = (reg_index == IDX_P6_DATA);   // R15
	assign hit_p6_dir  = (reg_index == IDX_P6_DIR);    // R15
	assign hit_p6_pull = (reg_index == IDX_P6_PULL);   // R15
	assign hit_disp    = (reg_index == IDX_DISP_CTRL);
	assign hit_power   = (reg_index == IDX_POWER);

	////////////////////////////////////////////////////////////////////
	// Read path

	logic [W-1:0] port5_read;            // Port 5 data view
	logic [W-1:0] port6_read;            // Port 6 data view
	logic [7:0]   rd_byte;               // Selected read byte
	logic [31:0]  next_readdata;

	// Output bits show the latch, input bits the live pin
	assign port5_read = (port5_direction & port5_data_latch)
		| (~port5_direction & port5_pin_sync);          // R17
	assign port6_read = (port6_direction & port6_data_latch)
		| (~port6_direction & port6_pin_sync);          // R9

	// Byte select; direction registers read back all ones
	assign rd_byte =
		hit_p5_data ? port5_read :
		hit_p5_dir  ? DIR_READBACK :                       // R19
		hit_p5_pull ? port5_pullup_enable :
		hit_p5_wake ? port5_wakeup_select :
		hit_p6_data ? port6_read :
		hit_p6_dir  ? DIR_READBACK :                       // R13
		hit_p6_pull ? port6_pullup_enable :                // R16
		hit_disp    ? {4'h0, segment_select_field} :
		hit_power   ? {5'h00, power_mode} :
		UNMAPPED_RD;

	// Upper lanes always read as zero
	assign next_readdata = rd_sample ? {24'h000000, rd_byte} : readdata;

	////////////////////////////////////////////////////////////////////
	// Handshake flops

	logic next_waitrequest;

	// High at rest, low for exactly one cycle per request
	assign next_waitrequest = ~((read | write) & waitrequest);

	// Bus answer flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h00000000;
		end else begin
			waitrequest <= next_waitrequest;
			readdata    <= next_readdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Port 5 registers

	// Direction and data latch
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			port5_data_latch <= RST_BYTE;
			port5_direction  <= RST_BYTE;                  // R19
		end else begin
			if (wr_take && hit_p5_data)
				port5_data_latch <= writedata[7:0];
			if (wr_take && hit_p5_dir)
				port5_direction  <= writedata[7:0];      // R18
		end
	end

	// Pull-up enables and wakeup role
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			port5_pullup_enable <= RST_BYTE;               // R2
			port5_wakeup_select <= RST_BYTE;               // R4
		end else begin
			if (wr_take && hit_p5_pull)
				port5_pullup_enable <= writedata[7:0];
			if (wr_take && hit_p5_wake)
				port5_wakeup_select <= writedata[7:0];   // R5
		end
	end

	////////////////////////////////////////////////////////////////////
	// Port 6 registers

	// Direction, data latch and pull-up enables
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			port6_data_latch    <= RST_BYTE;               // R10
			port6_direction     <= RST_BYTE;               // R14
			port6_pullup_enable <= RST_BYTE;               // R16
		end else begin
			if (wr_take && hit_p6_data)
				port6_data_latch    <= writedata[7:0];
			if (wr_take && hit_p6_dir)
				port6_direction     <= writedata[7:0];   // R11
			if (wr_take && hit_p6_pull)
				port6_pullup_enable <= writedata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Display and operating mode registers

	// Segment code and power mode, both software written
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			segment_select_field <= RST_SEG_FIELD;
			power_mode           <= RST_POWER;
		end else begin
			if (wr_take && hit_disp)
				segment_select_field <= writedata[SEG_FIELD_MSB:SEG_FIELD_LSB];
			if (wr_take && hit_power)
				power_mode <= writedata[POWER_MSB:POWER_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Segment takeover decode

	logic         p5_seg_hi;             // Port 5 pins 7..4 claimed
	logic         p5_seg_lo;             // Port 5 pins 3..0 claimed
	logic         p6_seg_hi;             // Port 6 pins 7..4 claimed
	logic         p6_seg_lo;             // Port 6 pins 3..0 claimed
	logic [W-1:0] port5_seg_claim;
	logic [W-1:0] port6_seg_claim;

	// Port 5 upper nibble on 1***, lower nibble on 1**1
	assign p5_seg_hi = segment_select_field[3];                        // R6
	assign p5_seg_lo = segment_select_field[3] & segment_select_field[0]; // R7
	// Port 6 upper on 011* or 1***, lower on 0111 or 1***
	assign p6_seg_hi = segment_select_field[3]
		| (segment_select_field[3:1] == 3'h3);          // R12
	assign p6_seg_lo = segment_select_field[3]
		| (segment_select_field == 4'h7);               // R12

	// Spread nibble claims over the pins
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_claim
			assign port5_seg_claim[gi] = (gi >= W/2) ? p5_seg_hi : p5_seg_lo;
			assign port6_seg_claim[gi] = (gi >= W/2) ? p6_seg_hi : p6_seg_lo;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Operating mode decode

	logic mode_hold;                     // Pins keep their state
	logic mode_hiz;                      // Pins released, pull-up kept

	// Sleep modes freeze; standby and watch release drive
	assign mode_hold = (power_mode == PWR_SLEEP) | (power_mode == PWR_SUBSLEEP);
	assign mode_hiz  = (power_mode == PWR_STANDBY) | (power_mode == PWR_WATCH);

	////////////////////////////////////////////////////////////////////
	// Pin control

	// Port 5 has wakeup roles and segment takeover
	wsgp_pin_ctl #(
		.W         (W)
	) u_pins5 (
		.clk       (clk),
		.reset_n   (reset_n),
		.dir       (port5_direction),
		.data      (port5_data_latch),
		.pullen    (port5_pullup_enable),
		.wake_sel  (port5_wakeup_select),
		.seg_claim (port5_seg_claim),
		.seg_data  (port5_segment_output),
		.hold      (mode_hold),
		.hiz       (mode_hiz),
		.pin_out   (port5_pin_out),
		.pin_oe    (port5_pin_oe),
		.pull_on   (port5_pullup_on)
	);

	// Port 6 has no wakeup role
	wsgp_pin_ctl #(
		.W         (W)
	) u_pins6 (
		.clk       (clk),
		.reset_n   (reset_n),
		.dir       (port6_direction),
		.data      (port6_data_latch),
		.pullen    (port6_pullup_enable),
		.wake_sel  ({W{1'b0}}),
		.seg_claim (port6_seg_claim),
		.seg_data  (port6_segment_output),
		.hold      (mode_hold),
		.hiz       (mode_hiz),
		.pin_out   (port6_pin_out),
		.pin_oe    (port6_pin_oe),
		.pull_on   (port6_pullup_on)
	);

	////////////////////////////////////////////////////////////////////
	// Wakeup forwarding

	logic [W-1:0] wake_role;             // Pin acts as wakeup input
	logic [W-1:0] next_wakeup;

	// Segment claim outranks the wakeup role
	assign wake_role   = port5_wakeup_select & ~port5_seg_claim;      // R5 R20
	assign next_wakeup = wake_role & port5_pin_sync;                  // R22

	// Registered so the output is a flop
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			wakeup_input <= '0;
		else
			wakeup_input <= next_wakeup;
	end

endmodule : wsgp_top

// ===== dv/wsgp_pin_model.sv
// Purpose: Pins, pull-ups and far-side drivers around both ports
// Assumes: One model instance per port
// Notes:   A released pin with no pull and no driver toggles each clock
`timescale 1ns/1ps
module wsgp_pin_model #(
	parameter int W = 8 // Pins in the port
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] pin_out, // Device drive level
	input  wire logic [W-1:0] pin_oe,  // Device drives pin
	input  wire logic [W-1:0] pull_on, // Device pull-up
	input  wire logic [W-1:0] ext_val, // Outside driver level
	input  wire logic [W-1:0] ext_en,  // Outside driver active
	output logic      [W-1:0] pin_in
);
	////////////////////////////////////////////////////////////////////
	logic [W-1:0] float_lvl = '0; // Undriven pins: never a stale level

	// Floating pins wander so a missed drive cannot pass by luck
	always_ff @(posedge clk) begin
		float_lvl <= ~float_lvl;
	end

	// Device drive wins, then outside driver, then pull-up
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pull_on | float_lvl));
endmodule : wsgp_pin_model

// ===== dv/wsgp_top_sva.sv
// Purpose: Port-level checks of bus timing and pin control
// Assumes: Single clock, reset_n async active low
// Notes:   Bound into every wsgp_top instance
`timescale 1ns/1ps
module wsgp_top_chk
	import wsgp_pkg::*;
#(
	parameter int W = PORT_W // Pins per port
) (
	input wire logic         clk,
	input wire logic         reset_n,
	input wire logic         read,
	input wire logic         write,
	input wire logic [31:0]  readdata,
	input wire logic         waitrequest,
	input wire logic [W-1:0] port5_pin_in,
	input wire logic [W-1:0] port5_pin_oe,
	input wire logic [W-1:0] port6_pin_oe,
	input wire logic [W-1:0] port5_pullup_on,
	input wire logic [W-1:0] port6_pullup_on,
	input wire logic [W-1:0] wakeup_input
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////
	// Bus handshake: exactly one wait cycle per request
	a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered after one wait");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than a cycle");
	a_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
		else $error("answer without request");
	a_rd_upper: assert property (!waitrequest |-> readdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	a_rd_hold: assert property ($changed(readdata) |-> $past(read))
		else $error("read data moved without a read");
	////////////////////////////////////////////////////////////////////
	// Pin control moves only after a register write lands
	a_oe_cause: assert property ($changed({port5_pin_oe, port6_pin_oe})
		|-> $past(write, 2) || $past(write, 3))
		else $error("pin enable changed without a write");
	a_pull_cause: assert property ($changed({port5_pullup_on, port6_pullup_on})
		|-> $past(write, 2) || $past(write, 3))
		else $error("pull-up changed without a write");
	// Wakeup pins pass pin level and never drive
	a_wake_level: assert property ((wakeup_input & ~($past(port5_pin_in, 2)
		| $past(port5_pin_in, 3) | $past(port5_pin_in, 4))) == '0)
		else $error("wakeup high without pin high");
	a_wake_no_drive: assert property ((wakeup_input & port5_pin_oe) == '0)
		else $error("wakeup pin is driven");
endmodule : wsgp_top_chk

bind wsgp_top wsgp_top_chk #(.W(W)) u_wsgp_top_chk (.clk(clk), .reset_n(reset_n),
	.read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
	.port5_pin_in(port5_pin_in), .port5_pin_oe(port5_pin_oe), .port6_pin_oe(port6_pin_oe),
	.port5_pullup_on(port5_pullup_on), .port6_pullup_on(port6_pullup_on),
	.wakeup_input(wakeup_input));

// ===== dv/tb_wakeup_segment_gpio_ports.sv
// Purpose: Register-level tests of both GPIO ports
// Assumes: Avalon-MM master tasks, one access at a time
// Notes:   Pin outputs are compared after a fixed settle of four edges
`timescale 1ns/1ps
module tb_wakeup_segment_gpio_ports
	import wsgp_pkg::*;
;
	logic              clk;
	logic              reset_n;
	logic [ADDR_W-1:0] address;
	logic              read, write;
	logic [31:0]       writedata, readdata;
	logic [3:0]        byteenable;
	logic              waitrequest;
	logic [7:0]        p5_in, p5_out, p5_oe, p5_pull, p6_in, p6_out, p6_oe, p6_pull;
	logic [7:0]        wake, seg5, seg6, ext5, ext5_en, ext6, ext6_en;
	logic [7:0]        rd_val;          // Last read byte
	int                n_fail, tests_run;

	wsgp_top u_wsgp_top (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .port5_pin_in(p5_in), .port5_pin_out(p5_out),
		.port5_pin_oe(p5_oe), .port5_pullup_on(p5_pull), .port5_segment_output(seg5),
		.wakeup_input(wake), .port6_pin_in(p6_in), .port6_pin_out(p6_out),
		.port6_pin_oe(p6_oe), .port6_pullup_on(p6_pull), .port6_segment_output(seg6));
	wsgp_pin_model u_wsgp_pin_model_5 (.clk(clk), .pin_out(p5_out), .pin_oe(p5_oe),
		.pull_on(p5_pull), .ext_val(ext5), .ext_en(ext5_en), .pin_in(p5_in));
	wsgp_pin_model u_wsgp_pin_model_6 (.clk(clk), .pin_out(p6_out), .pin_oe(p6_oe),
		.pull_on(p6_pull), .ext_val(ext6), .ext_en(ext6_en), .pin_in(p6_in));
	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One Avalon access; held until waitrequest is sampled low
	task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] wd,
		input logic [3:0] be);
		address    <= {idx, 2'b00};
		read       <= ~wr;
		write      <= wr;
		writedata  <= {24'h000000, wd};
		byteenable <= be;
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd_val = readdata[7:0];
		read  <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic wr(input logic [15:0] idx, input logic [7:0] v);
		bus(idx, 1'b1, v, 4'hF);
	endtask : wr

	task automatic rdc(input logic [15:0] idx, input logic [7:0] exp, input string nm);
		bus(idx, 1'b0, 8'h00, 4'hF);
		chk(nm, rd_val, exp);
	endtask : rdc

	task automatic settle();
		repeat (4) @(posedge clk);
	endtask : settle

	task automatic close_out();
		if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out

	// Watchdog: tests need well under 2000 cycles
	initial begin
		#(25 * 20000);
		n_fail++;
		close_out();
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		static logic [3:0] segv [5] = '{4'h0, 4'h6, 4'h7, 4'h8, 4'h9};
		static logic [7:0] m5   [5] = '{8'h00, 8'h00, 8'h00, 8'hF0, 8'hFF};
		static logic [7:0] m6   [5] = '{8'h00, 8'hF0, 8'hFF, 8'hFF, 8'hFF};
		static logic [2:0] pm   [6] = '{PWR_SLEEP, PWR_ACTIVE, PWR_SUBSLEEP, PWR_STANDBY,
			PWR_WATCH, PWR_SUBACTIVE};
		static int         kind [6] = '{1, 0, 1, 2, 2, 0}; // 0 run, 1 hold, 2 released
		logic [7:0] v, pout, poe;
		reset_n = 1'b0; address = '0; read = 1'b0; write = 1'b0; writedata = '0;
		byteenable = 4'h0; seg5 = 8'hC3; seg6 = 8'h3C;
		ext5 = 8'h30; ext5_en = 8'hF0; ext6 = 8'h5A; ext6_en = 8'hFF;
		n_fail = 0; tests_run = 0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		// Reset values and write-only readback
		rdc(IDX_P5_PULL, RST_BYTE, "p5 pull reg");
		rdc(IDX_P5_WAKE, RST_BYTE, "p5 wake reg");
		rdc(IDX_P6_PULL, RST_BYTE, "p6 pull reg");
		rdc(IDX_P5_DIR, DIR_READBACK, "p5 dir reg");
		rdc(IDX_P6_DIR, DIR_READBACK, "p6 dir reg");
		rdc(16'h0100, UNMAPPED_RD, "unmapped");
		chk("pull after reset", {p5_pull, p6_pull}, 16'h0000);
		rdc(IDX_P6_DATA, 8'h5A, "p6 pins");
		// Port 6 direction, latch and pin read mix
		wr(IDX_P6_DIR, 8'hF0);
		rdc(IDX_P6_DATA, 8'h0A, "p6 latch reset");
		wr(IDX_P6_DATA, 8'hA5);
		bus(IDX_P6_DATA, 1'b1, 8'h00, 4'h0);
		settle();
		chk("p6 oe", p6_oe, 8'hF0);
		chk("p6 out", p6_out & 8'hF0, 8'hA0);
		rdc(IDX_P6_DATA, 8'hAA, "p6 mixed read");
		rdc(IDX_P6_DIR, DIR_READBACK, "p6 dir written");
		wr(IDX_P6_PULL, 8'hFF);
		settle();
		chk("p6 pull", p6_pull, 8'h0F);
		rdc(IDX_P6_PULL, 8'hFF, "p6 pull rw");
		// Port 5 pull-ups, read mix, wakeup role
		wr(IDX_P5_DIR, 8'h0F);
		wr(IDX_P5_PULL, 8'hFF);
		wr(IDX_P5_DATA, 8'h06);
		settle();
		chk("p5 pull", p5_pull, 8'hF0);
		chk("p5 oe", p5_oe, 8'h0F);
		chk("p5 out", p5_out & 8'h0F, 8'h06);
		rdc(IDX_P5_PULL, 8'hFF, "p5 pull rw");
		rdc(IDX_P5_DATA, 8'h36, "p5 mixed read");
		ext5 <= 8'hB1;
		ext5_en <= 8'hFF;
		wr(IDX_P5_WAKE, 8'h81);
		settle();
		chk("wakeup", wake, 8'h81);
		chk("p5 oe wake", p5_oe, 8'h0E);
		rdc(IDX_P5_WAKE, 8'h81, "p5 wake rw");
		// Wakeup roles left on so segment priority over them shows
		wr(IDX_P5_WAKE, 8'hFF);
		wr(IDX_P5_DIR, 8'h00);
		wr(IDX_P6_DIR, 8'h00);
		// Segment takeover for five field patterns: 0, 6, 7, 8 and 9
		for (int i = 0; i < 5; i++) begin
			wr(IDX_DISP_CTRL, {4'h0, segv[i]});
			settle();
			chk("p5 seg oe", p5_oe, m5[i]);
			chk("p5 seg out", p5_out & m5[i], seg5 & m5[i]);
			chk("p6 seg oe", p6_oe, m6[i]);
			chk("p6 seg out", p6_out & m6[i], seg6 & m6[i]);
			chk("p5 seg wake", wake & m5[i], 8'h00);
		end
		wr(IDX_DISP_CTRL, 8'h00);
		wr(IDX_P5_WAKE, 8'h00);
		wr(IDX_P5_DIR, 8'h0F);
		// Operating modes: run, hold, release
		wr(IDX_P6_DIR, 8'h0F);
		wr(IDX_P6_DATA, 8'h00);
		pout = 8'h00;
		poe = 8'h0F;
		for (int i = 0; i < 6; i++) begin
			v = 8'(8'h11 * (i + 1));
			wr(IDX_POWER, {5'h00, pm[i]});
			wr(IDX_P6_DATA, v);
			settle();
			if (kind[i] == 0) begin
				pout = v & 8'h0F;
				poe = 8'h0F;
			end else if (kind[i] == 2) begin
				pout = 8'h00;
				poe = 8'h00;
			end
			chk("p6 mode oe", p6_oe, poe);
			chk("p6 mode out", p6_out & 8'h0F, pout);
			chk("p6 mode pull", p6_pull, 8'hF0);
			chk("p5 mode oe", p5_oe, poe);
			chk("p5 mode out", p5_out & 8'h0F, poe & 8'h06);
			chk("p5 mode pull", p5_pull, 8'hF0);
		end
		// Second reset mid-run: pins and registers clear again
		reset_n <= 1'b0;
		@(posedge clk);
		chk("pull after mid reset", {p5_pull, p6_pull}, 16'h0000);
		chk("oe after mid reset", {p5_oe, p6_oe}, 16'h0000);
		reset_n <= 1'b1;
		@(posedge clk);
		rdc(IDX_P5_PULL, RST_BYTE, "p5 pull mid reset");
		close_out();
	end
endmodule : tb_wakeup_segment_gpio_ports
